// >>> tb_sine_pattern_generator.sv
// Self-checking testbench for the sine pattern generator
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_sine_pattern_generator;
    logic clock = 0;
    logic nrst = 0;
    logic [7:0] wave_control_reg = 8'h00;
    logic [5:0] step_divider_reg = 6'h00;
    logic [4:0] half_count_reg = 5'h00;
    logic cpu_req = 0;
    logic cpu_we = 0;
    logic [1:0] cpu_bank = 2'h0;
    logic [7:0] cpu_addr = 8'h00;
    logic [7:0] cpu_wdata = 8'h00;
    logic [7:0] cpu_rdata;
    logic cpu_hit, cpu_blocked, dac_strobe, dac_power_up, output_buffer_amp;
    logic [9:0] dac_code;
    logic [8:0] pat[32];
    int errors = 0;
    int num_checks = 0;
    wave_generator_enable_top wave_generator_enable_top_i (.clock, .nrst, .wave_control_reg,
        .step_divider_reg, .half_count_reg, .cpu_req, .cpu_we, .cpu_bank,
        .cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_hit, .cpu_blocked,
        .dac_code, .dac_strobe, .dac_power_up, .output_buffer_amp);
    wave_generator_enable_dac_model wave_generator_enable_dac_model_i (.clock, .dac_code, .dac_strobe,
        .dac_power_up, .output_buffer_amp);
    always #5 clock = ~clock;
    // ----
    // Scenarios
    // ----
    task automatic cpu(input logic we, input logic [1:0] bk,
        input logic [7:0] a, input logic [7:0] d, input logic hit,
        input logic blk, input logic [7:0] rd);
        @(negedge clock);
        cpu_req = 1'b1;
        cpu_we = we;
        cpu_bank = bk;
        cpu_addr = a;
        cpu_wdata = d;
        @(posedge clock);
        #1;
        `CHK({cpu_hit, cpu_blocked}, {hit, blk})
        if (!we && (hit || blk)) `CHK(cpu_rdata, rd)
        @(negedge clock);
        cpu_req = 1'b0;
    endtask
    task automatic t_load;
        for (int i = 0; i < 32; i++) begin
            pat[i] = 9'(15 + i * 15);
            cpu(1, 2'h2, 8'(64 + 2 * i), pat[i][7:0], 1, 0, 0);
            cpu(1, 2'h2, 8'(65 + 2 * i), {7'h0, pat[i][8]}, 1, 0, 0);
        end
        cpu(0, 2'h2, 8'h7E, 0, 1, 0, pat[31][7:0]);
        cpu(0, 2'h2, 8'h7F, 0, 1, 0, {7'h0, pat[31][8]});
        cpu(1, 2'h1, 8'h40, 8'hAA, 0, 0, 0);
        cpu(1, 2'h2, 8'h3F, 8'hAA, 0, 0, 0);
        cpu(0, 2'h2, 8'h40, 0, 1, 0, pat[0][7:0]);
    endtask
    task automatic t_play(input int n, input int h);
        int w;
        logic [9:0] e;
        wave_generator_enable_dac_model_i.codes.delete();
        wave_generator_enable_dac_model_i.stamps.delete();
        @(negedge clock);
        step_divider_reg = 6'(n - 1);
        half_count_reg = 5'(h - 1);
        wave_control_reg = 8'h80;
        cpu(1, 2'h2, 8'h40, 8'h55, 0, 1, 0);
        cpu(0, 2'h2, 8'h41, 0, 0, 1, 0);
        w = 0;
        while (wave_generator_enable_dac_model_i.codes.size() < 4 * h + 1 && w < 800) begin
            @(posedge clock);
            w++;
        end
        if (w >= 800) begin
            errors++;
            print_verdict();
        end
        for (int k = 0; k < 4 * h; k++) begin
            e = 10'(pat[k % h]);
            e = (k % (2 * h) < h) ? wave_generator_enable_pkg::WAVE_GENERATOR_ENABLE_MID + e
                : wave_generator_enable_pkg::WAVE_GENERATOR_ENABLE_MID - e;
            `CHK(wave_generator_enable_dac_model_i.codes[k], e)
            `CHK(int'((wave_generator_enable_dac_model_i.stamps[k + 1]
                - wave_generator_enable_dac_model_i.stamps[k]) / 10.0), n)
        end
        `CHK(int'((wave_generator_enable_dac_model_i.stamps[2 * h]
            - wave_generator_enable_dac_model_i.stamps[0]) / 10.0), 2 * n * h)
        @(negedge clock);
        wave_control_reg = 8'h00;
        @(posedge clock);
        #1;
        `CHK({dac_code, dac_power_up}, {wave_generator_enable_pkg::WAVE_GENERATOR_ENABLE_MID, 1'b0})
        cpu(0, 2'h2, 8'h40, 0, 1, 0, pat[0][7:0]);
        `CHK(wave_generator_enable_dac_model_i.unpowered, 0)
    endtask
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #500000;
        errors++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge clock);
        @(negedge clock);
        nrst = 1'b1;
        `CHK({dac_code, dac_strobe, dac_power_up}, {10'h200, 2'b00})
        t_load();
        t_play(3, 4);
        t_play(2, 32);
        t_play(64, 1);
        print_verdict();
    end
endmodule

// >>> wave_generator_enable_chk.sv
// Port assertions for the sine pattern generator
`timescale 1ns/1ps
module wave_generator_enable_chk
    import wave_generator_enable_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Control and CPU port
    input wire logic [7:0] wave_control_reg,
    input wire logic [WAVE_GENERATOR_ENABLE_STEP_W-1:0] step_divider_reg,
    input wire logic cpu_req,
    input wire logic [1:0] cpu_bank,
    input wire logic [7:0] cpu_addr,
    input wire logic [7:0] cpu_rdata,
    input wire logic cpu_hit,
    input wire logic cpu_blocked,
    // DAC side
    input wire logic [WAVE_GENERATOR_ENABLE_DAC_W-1:0] dac_code,
    input wire logic dac_strobe,
    input wire logic dac_power_up,
    input wire logic output_buffer_amp
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    logic en;
    logic area;
    logic seen;
    logic [7:0] gap;
    assign en = wave_control_reg[WAVE_GENERATOR_ENABLE_EN_BIT];
    assign area = cpu_req && cpu_bank == WAVE_GENERATOR_ENABLE_PAT_BANK
        && cpu_addr >= WAVE_GENERATOR_ENABLE_PAT_BASE && cpu_addr <= WAVE_GENERATOR_ENABLE_PAT_LAST;
    // Gap only judged between strobes of one run
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            gap <= 8'h00;
            seen <= 1'b0;
        end else begin
            gap <= dac_strobe ? 8'h01 : gap + 8'h01;
            seen <= dac_power_up && (seen || dac_strobe);
        end
    end
    sequence s_ok;
        cpu_hit && !cpu_blocked;
    endsequence
    sequence s_first;
        ##[1:70] dac_strobe;
    endsequence
    property p_hit;
        area && !en |=> s_ok;
    endproperty
    a_hit: assert property (p_hit)
        else $error("pattern access not taken");
    property p_block;
        area && en |=> cpu_blocked && !cpu_hit && cpu_rdata == 8'h00;
    endproperty
    a_block: assert property (p_block)
        else $error("access not blocked");
    property p_other;
        cpu_req && !area |=> !cpu_hit && !cpu_blocked;
    endproperty
    a_other: assert property (p_other)
        else $error("stray access answered");
    property p_on;
        en |=> dac_power_up;
    endproperty
    a_on: assert property (p_on) else $error("no power up");
    property p_off;
        !en |=> !dac_power_up && dac_code == WAVE_GENERATOR_ENABLE_MID;
    endproperty
    a_off: assert property (p_off) else $error("no power down");
    property p_amp;
        output_buffer_amp == dac_power_up;
    endproperty
    a_amp: assert property (p_amp) else $error("amp power differs");
    property p_first;
        $rose(en) |-> s_first;
    endproperty
    a_first: assert property (p_first) else $error("no first strobe");
    property p_gap;
        dac_strobe && seen |-> gap == 8'(step_divider_reg) + 8'h01;
    endproperty
    a_gap: assert property (p_gap) else $error("strobe spacing wrong");
    property p_live;
        dac_strobe |-> dac_power_up;
    endproperty
    a_live: assert property (p_live) else $error("strobe while off");
endmodule
bind wave_generator_enable_top wave_generator_enable_chk wave_generator_enable_chk_i (.clock, .nrst, .wave_control_reg,
    .step_divider_reg, .cpu_req, .cpu_bank, .cpu_addr, .cpu_rdata,
    .cpu_hit, .cpu_blocked, .dac_code, .dac_strobe, .dac_power_up,
    .output_buffer_amp);

// >>> wave_generator_enable_dac_model.sv
// Behavioural DAC and output amplifier fed by the generator
`timescale 1ns/1ps
module wave_generator_enable_dac_model (
    // Clock
    input wire logic clock,
    // DAC feed
    input wire logic [9:0] dac_code,
    input wire logic dac_strobe,
    input wire logic dac_power_up,
    input wire logic output_buffer_amp
);
    logic [9:0] codes[$];
    realtime stamps[$];
    int unpowered = 0;
    // A powered-down converter ignores its strobe
    always @(posedge clock) begin
        if (dac_strobe && dac_power_up && output_buffer_amp) begin
            codes.push_back(dac_code);
            stamps.push_back($realtime);
        end else if (dac_strobe) begin
            unpowered++;
        end
    end
endmodule

// >>> wave_generator_enable_divider.sv
// Integer divide-by-N rate divider giving the sample step enable
`timescale 1ns/1ps
module wave_generator_enable_divider #(
    parameter int STEP_W = 6
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Control
    input wire logic run,
    input wire logic [STEP_W-1:0] step_divider_reg,
    // Step enable
    output logic tick
);
    typedef struct packed {
        logic [STEP_W:0] cnt;
        logic tick;
    } wave_generator_enable_div_st_t;

    wave_generator_enable_div_st_t st;
    wave_generator_enable_div_st_t next_st;
    logic [STEP_W:0] n_val;

    // One tick every N clocks, so DN ticks span M = N*DN clocks
    assign n_val = {1'b0, step_divider_reg} + 1'b1;
    assign tick = st.tick;

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (!run) begin
            next_st.cnt = '0;
        end else if (st.cnt + 1'b1 >= n_val) begin
            next_st.cnt = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// >>> wave_generator_enable_fifo.sv
// Sample FIFO between the pattern reader and the DAC register
`timescale 1ns/1ps
module wave_generator_enable_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    input wire logic flush,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } wave_generator_enable_fifo_st_t;

    wave_generator_enable_fifo_st_t st;
    wave_generator_enable_fifo_st_t next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // Count is one bit wider than the pointers so that full is not zero
    assign in_ready = (st.count != (AW + 1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (st.count != '0);
    assign out_data = mem[st.rd];
    assign push = in_valid && in_ready && !flush;
    assign pop = out_valid && out_ready && !flush;

    always_comb begin
        next_st = st;
        if (flush) begin
            next_st = '0;
        end else begin
            if (push) begin
                next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
            end
            if (pop) begin
                next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
            end
            next_st.count = st.count + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Storage has no reset; only words below count are ever read
    always_ff @(posedge clock) begin
        if (push) begin
            mem[st.wr] <= in_data;
        end
    end
endmodule

// >>> wave_generator_enable_pkg.sv
// Package of constants and types for the sine pattern generator
package wave_generator_enable_pkg;
    // ----------------------------------------------------------------
    // Pattern memory map
    // ----------------------------------------------------------------
    localparam int WAVE_GENERATOR_ENABLE_DEPTH = 32;
    localparam int WAVE_GENERATOR_ENABLE_SAMPLE_W = 9;
    localparam int WAVE_GENERATOR_ENABLE_DAC_W = 10;
    localparam logic [7:0] WAVE_GENERATOR_ENABLE_PAT_BASE = 8'h40;
    localparam logic [7:0] WAVE_GENERATOR_ENABLE_PAT_LAST = 8'h7F;
    localparam logic [1:0] WAVE_GENERATOR_ENABLE_PAT_BANK = 2'h2;
    localparam int WAVE_GENERATOR_ENABLE_BYTE_LO_LSB = 0;
    localparam int WAVE_GENERATOR_ENABLE_BYTE_HI_BIT = 8;
    // ----------------------------------------------------------------
    // Control fields
    // ----------------------------------------------------------------
    localparam int WAVE_GENERATOR_ENABLE_EN_BIT = 7;
    localparam int WAVE_GENERATOR_ENABLE_STEP_W = 6;
    localparam int WAVE_GENERATOR_ENABLE_HALF_W = 5;
    localparam logic WAVE_GENERATOR_ENABLE_EN_RST = 1'b0;
    localparam logic [5:0] WAVE_GENERATOR_ENABLE_STEP_RST = 6'h00;
    localparam logic [4:0] WAVE_GENERATOR_ENABLE_HALF_RST = 5'h00;
    localparam int WAVE_GENERATOR_ENABLE_FIFO_DEPTH = 16;
    // Mid-scale of the DAC, used to mirror the second half cycle
    localparam logic [9:0] WAVE_GENERATOR_ENABLE_MID = 10'h200;

    typedef enum logic [1:0] {
        WAVE_GENERATOR_ENABLE_IDLE = 2'b00,
        WAVE_GENERATOR_ENABLE_POS = 2'b01,
        WAVE_GENERATOR_ENABLE_NEG = 2'b11
    } wave_generator_enable_state_t;
endpackage

// >>> wave_generator_enable_top.sv
// Sine pattern generator: pattern RAM, step divider, player, DAC feed
// ----------------------------------------------------------------
// Functional notes
// - Output period is M = N*DN system clocks, spanning 5 to 50 kHz.
// - The divider steps the sample counter at clock*DN/M, once per N.
// - The pattern memory holds 32 samples of 9 bits.
// - Only a half cycle of samples 0..HALF_CYCLE_SAMPLES-1 is stored and replayed.
// - Pattern bytes sit in bank 2 at 40H-7FH, low byte even, bit 8 odd.
// - While enabled, CPU reads and writes of the pattern area are blocked.
// - Running, each fetched 9-bit sample is passed to the 10-bit DAC.
// - Enable bit 7 starts the generator; clear powers down DAC and amp.
// - Divider N is the 6-bit field plus one.
// - Half-cycle count HALF_CYCLE_SAMPLES is the 5-bit field plus one.
// ----------------------------------------------------------------
`timescale 1ns/1ps
module wave_generator_enable_top
    import wave_generator_enable_pkg::*;
#(
    parameter int DEPTH = WAVE_GENERATOR_ENABLE_DEPTH,
    parameter int FIFO_DEPTH = WAVE_GENERATOR_ENABLE_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Control settings from the CPU side
    input wire logic [7:0] wave_control_reg,
    input wire logic [WAVE_GENERATOR_ENABLE_STEP_W-1:0] step_divider_reg,
    input wire logic [WAVE_GENERATOR_ENABLE_HALF_W-1:0] half_count_reg,
    // CPU data memory port
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire logic [1:0] cpu_bank,
    input wire logic [7:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    output logic cpu_hit,
    output logic cpu_blocked,
    // DAC side
    output logic [WAVE_GENERATOR_ENABLE_DAC_W-1:0] dac_code,
    output logic dac_strobe,
    output logic dac_power_up,
    output logic output_buffer_amp
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        wave_generator_enable_state_t state;
        logic [AW-1:0] rd_idx;
        logic rd_neg;
        logic [WAVE_GENERATOR_ENABLE_DAC_W-1:0] dac_code;
        logic dac_strobe;
        logic power;
        logic [7:0] cpu_rdata;
        logic cpu_hit;
        logic cpu_blocked;
    } wave_generator_enable_top_st_t;

    wave_generator_enable_top_st_t st;
    wave_generator_enable_top_st_t next_st;
    logic [WAVE_GENERATOR_ENABLE_SAMPLE_W-1:0] pattern [DEPTH];
    logic wave_generator_enable;
    logic tick;
    logic in_pat;
    logic [AW-1:0] cpu_idx;
    logic cpu_hi;
    logic [AW-1:0] last_idx;
    logic [WAVE_GENERATOR_ENABLE_SAMPLE_W-1:0] sample;
    logic [WAVE_GENERATOR_ENABLE_DAC_W-1:0] fill_code;
    logic fill_valid;
    logic fill_ready;
    logic drain_valid;
    logic [WAVE_GENERATOR_ENABLE_DAC_W-1:0] drain_code;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic pat_area(input logic [1:0] bank,
                                      input logic [7:0] addr);
        return bank == WAVE_GENERATOR_ENABLE_PAT_BANK && addr >= WAVE_GENERATOR_ENABLE_PAT_BASE
            && addr <= WAVE_GENERATOR_ENABLE_PAT_LAST;
    endfunction

    // Mirror about mid-scale for the negative half cycle
    function automatic logic [WAVE_GENERATOR_ENABLE_DAC_W-1:0] to_dac(
        input logic [WAVE_GENERATOR_ENABLE_SAMPLE_W-1:0] s, input logic neg);
        logic [WAVE_GENERATOR_ENABLE_DAC_W-1:0] up;
        up = {1'b0, s};
        return neg ? WAVE_GENERATOR_ENABLE_MID - up : WAVE_GENERATOR_ENABLE_MID + up;
    endfunction

    assign wave_generator_enable = wave_control_reg[WAVE_GENERATOR_ENABLE_EN_BIT];
    assign last_idx = AW'(half_count_reg);
    assign in_pat = pat_area(cpu_bank, cpu_addr);
    assign cpu_idx = AW'((cpu_addr - WAVE_GENERATOR_ENABLE_PAT_BASE) >> 1);
    assign cpu_hi = cpu_addr[0];
    assign sample = pattern[st.rd_idx];
    assign fill_code = to_dac(sample, st.rd_neg);
    assign fill_valid = (st.state != WAVE_GENERATOR_ENABLE_IDLE);

    // ----------------------------------------------------------------
    // Step divider
    // ----------------------------------------------------------------
    wave_generator_enable_divider #(
        .STEP_W(WAVE_GENERATOR_ENABLE_STEP_W)
    ) u_div (
        .clock(clock),
        .nrst(nrst),
        .run(wave_generator_enable),
        .step_divider_reg(step_divider_reg),
        .tick(tick)
    );

    // ----------------------------------------------------------------
    // Sample FIFO towards the DAC; drained one word per step
    // ----------------------------------------------------------------
    wave_generator_enable_fifo #(
        .WIDTH(WAVE_GENERATOR_ENABLE_DAC_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .nrst(nrst),
        .flush(!wave_generator_enable),
        .in_valid(fill_valid),
        .in_ready(fill_ready),
        .in_data(fill_code),
        .out_valid(drain_valid),
        .out_ready(tick),
        .out_data(drain_code)
    );

    // ----------------------------------------------------------------
    // Player and CPU access
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.dac_strobe = 1'b0;
        next_st.cpu_hit = 1'b0;
        next_st.cpu_blocked = 1'b0;
        next_st.power = wave_generator_enable;
        case (st.state)
            WAVE_GENERATOR_ENABLE_IDLE: begin
                next_st.rd_idx = '0;
                next_st.rd_neg = 1'b0;
                if (wave_generator_enable) begin
                    next_st.state = WAVE_GENERATOR_ENABLE_POS;
                end
            end
            WAVE_GENERATOR_ENABLE_POS, WAVE_GENERATOR_ENABLE_NEG: begin
                if (!wave_generator_enable) begin
                    next_st.state = WAVE_GENERATOR_ENABLE_IDLE;
                    next_st.dac_code = WAVE_GENERATOR_ENABLE_MID;
                end else if (fill_ready) begin
                    // Fetch ahead; FIFO back-pressure paces the reader
                    if (st.rd_idx >= last_idx) begin
                        next_st.rd_idx = '0;
                        next_st.rd_neg = !st.rd_neg;
                        next_st.state = st.rd_neg ? WAVE_GENERATOR_ENABLE_POS : WAVE_GENERATOR_ENABLE_NEG;
                    end else begin
                        next_st.rd_idx = st.rd_idx + 1'b1;
                    end
                end
            end
            default: begin
                next_st.state = WAVE_GENERATOR_ENABLE_IDLE;
            end
        endcase
        // A tick left over at disable must not replace the parked mid code
        if (tick && drain_valid && wave_generator_enable) begin
            next_st.dac_code = drain_code;
            next_st.dac_strobe = 1'b1;
        end
        if (cpu_req && in_pat) begin
            if (wave_generator_enable) begin
                next_st.cpu_blocked = 1'b1;
                next_st.cpu_rdata = 8'h00;
            end else begin
                next_st.cpu_hit = 1'b1;
                if (!cpu_we) begin
                    next_st.cpu_rdata = cpu_hi
                        ? {7'h00, pattern[cpu_idx][WAVE_GENERATOR_ENABLE_BYTE_HI_BIT]}
                        : pattern[cpu_idx][7:WAVE_GENERATOR_ENABLE_BYTE_LO_LSB];
                end
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.state <= WAVE_GENERATOR_ENABLE_IDLE;
            st.dac_code <= WAVE_GENERATOR_ENABLE_MID;
            st.power <= WAVE_GENERATOR_ENABLE_EN_RST;
        end else begin
            st <= next_st;
        end
    end

    // Pattern RAM, written only while the generator is stopped
    always_ff @(posedge clock) begin
        if (cpu_req && cpu_we && in_pat && !wave_generator_enable) begin
            if (cpu_hi) begin
                pattern[cpu_idx][WAVE_GENERATOR_ENABLE_BYTE_HI_BIT] <= cpu_wdata[0];
            end else begin
                pattern[cpu_idx][7:0] <= cpu_wdata;
            end
        end
    end

    assign cpu_rdata = st.cpu_rdata;
    assign cpu_hit = st.cpu_hit;
    assign cpu_blocked = st.cpu_blocked;
    assign dac_code = st.dac_code;
    assign dac_strobe = st.dac_strobe;
    assign dac_power_up = st.power;
    assign output_buffer_amp = st.power;
endmodule
